/* rtl/lwb_pkg.sv */
// lwb_pkg: shared constants and types for the late-write burst memory control
// assumes: single 100 MHz clock domain
package lwb_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SLEEP_ENTRY_CYC = 2;
  localparam int unsigned SLEEP_EXIT_CYC  = 2;
  localparam int unsigned BURST_BITS      = 2;
  localparam logic [1:0]  BURST_RESET     = 2'h0;
  localparam int unsigned ADDR_W_DEF      = 20;
  localparam int unsigned DATA_W_DEF      = 36;
  localparam int unsigned LANES_DEF       = 4;
  localparam int unsigned WORDS_DEF       = 256;

  typedef enum logic [4:0] {
    LWB_IDLE  = 5'b0_0001,
    LWB_READ  = 5'b0_0010,
    LWB_WRITE = 5'b0_0100,
    LWB_DESEL = 5'b0_1000,
    LWB_ABORT = 5'b1_0000
  } lwb_cmd_e;

  typedef enum logic [3:0] {
    LWB_AWAKE   = 4'b0001,
    LWB_ENTER   = 4'b0010,
    LWB_ASLEEP  = 4'b0100,
    LWB_WAKING  = 4'b1000
  } lwb_sleep_e;
endpackage : lwb_pkg

/* rtl/lwb_burst_if.sv */
// lwb_burst_if: carries load/advance requests to the burst counter and its address back
// assumes: both ends on sys_clk
`timescale 1ns/1ns
`default_nettype none
interface lwb_burst_if;
  logic       load;
  logic       step;
  logic [1:0] start;
  logic       interleave;
  logic [1:0] addr;
  modport ctrl (output load, output step, output start, output interleave, input addr);
  modport cnt  (input load, input step, input start, input interleave, output addr);
endinterface : lwb_burst_if
`default_nettype wire

/* rtl/lwb_burst_counter.sv */
// lwb_burst_counter: 2-bit burst sequence, linear or interleaved
// assumes: load and step are never high together
`timescale 1ns/1ns
`default_nettype none
module lwb_burst_counter (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  nrst,
  // control side
  lwb_burst_if.cnt   bif
);
  typedef struct packed {
    logic [1:0] base;
    logic [1:0] count;
  } lwb_cnt_s;

  lwb_cnt_s st_reg;
  lwb_cnt_s st_next;

  always_comb begin
    st_next = st_reg;
    if (bif.load) begin
      st_next.base  = bif.start;
      st_next.count = lwb_pkg::BURST_RESET;
    end else if (bif.step) begin
      st_next.count = st_reg.count + 2'h1; // wraps after four
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // address for the next continue: one offset past the last access
  logic [1:0] offs;
  assign offs     = st_reg.count + 2'h1;
  // linear adds, interleaved xors the offset
  assign bif.addr = bif.interleave ? (st_reg.base ^ offs)
                                   : (st_reg.base + offs);
endmodule : lwb_burst_counter
`default_nettype wire

/* rtl/lwb_ctrl.sv */
// lwb_ctrl: command decode, late-write pipeline, data pin control and sleep for a burst memory
// assumes: all synchronous inputs meet timing to sys_clk; sleep_request and out_en_n arrive synchronous
// What this block does
// - load low, store high, all selects active, gate low starts a burst read.
// - load low, store low, a lane strobe low, selects active starts a burst write.
// - store low with no lane strobe is a write abort; nothing written, pins off.
// - load low with any select inactive deselects and starts no access.
// - next_or_load high continues with counter address; strobes pick write or abort.
// - continue after a deselect stays deselected with pins off.
// - clock gate high ignores the edge, holding address and state.
// - stall in pipelined read keeps bus driven; stall in write keeps it off.
// - reads with output enable high are dummy reads, pins off.
// - drivers turn off automatically during write cycles.
// - two-bit counter loads from low address bits, steps each continue.
// - counter returns to start after four accesses.
// - order select low gives linear sequence, start plus offset.
// - order select high gives interleaved sequence, start xor offset.
// - passthru select low is flow-through, high is pipelined.
// - passthru and sleep have no defaults; tie passthru high for pipelined and sleep low for awake.
// - sleep request high enters sleep after two cycles, keeping state.
// - sleep request low resumes operation after two cycles.
// - asleep: deselected, inputs ignored, outputs off.
// - outputs off during power-up.
// - pipelined read data appears one edge after the address edge.
// - flow-through read data comes one cycle earlier.
`timescale 1ns/1ns
`default_nettype none
module lwb_ctrl #(
  parameter int unsigned ADDR_W = lwb_pkg::ADDR_W_DEF,
  parameter int unsigned DATA_W = lwb_pkg::DATA_W_DEF,
  parameter int unsigned LANES  = lwb_pkg::LANES_DEF,
  parameter int unsigned WORDS  = lwb_pkg::WORDS_DEF
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // command pins
  input  wire logic              clk_gate_n,
  input  wire logic              next_or_load,
  input  wire logic              store_n,
  input  wire logic [LANES-1:0]  lane_strobe_n,
  input  wire logic              select_one_n,
  input  wire logic              select_two,
  input  wire logic              select_three_n,
  input  wire logic              out_en_n,
  input  wire logic [ADDR_W-1:0] addr,
  // mode pins, tie high and low when unused
  input  wire logic              seq_order_sel_n,
  input  wire logic              passthru_sel_n,
  input  wire logic              sleep_request,
  // data pins
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic      [DATA_W-1:0] dq_oe,
  // status
  output logic                   asleep
);
  localparam int unsigned LANE_W = DATA_W / LANES;
  localparam int unsigned IDX_W  = $clog2(WORDS);

  typedef struct packed {
    lwb_pkg::lwb_cmd_e   last;      // last command for continue decode
    logic [ADDR_W-1:0]   base;
    logic                cyc_vld;   // stage 1 access
    logic                cyc_wr;
    logic                cyc_drive;
    logic [ADDR_W-1:0]   cyc_addr;
    logic [LANES-1:0]    cyc_lanes;
    logic                w2_vld;    // pipelined write second stage
    logic [ADDR_W-1:0]   w2_addr;
    logic [LANES-1:0]    w2_lanes;
    logic                rd_drive;  // pipelined output register driving
    logic [DATA_W-1:0]   rd_data;
    lwb_pkg::lwb_sleep_e slp;
    logic [1:0]          slp_cnt;
    logic                oe;
    logic [DATA_W-1:0]   dout;
    logic                asleep;
  } lwb_ctrl_s;

  lwb_ctrl_s st_reg;
  lwb_ctrl_s st_next;

  logic [DATA_W-1:0] mem [WORDS];
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [LANES-1:0]  mem_wlanes;
  logic [DATA_W-1:0] mem_wmask;
  logic [DATA_W-1:0] rd_word;

  lwb_burst_if bif ();

  lwb_burst_counter u_cnt (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .bif     (bif)
  );

  // decoded command at this edge
  logic              run;
  logic              selected;
  logic              any_lane;
  logic              pipelined;
  logic [ADDR_W-1:0] cur_addr;
  logic              cur_wr;
  logic              cur_acc;

  always_comb begin
    pipelined = passthru_sel_n;
    run       = (st_reg.slp == lwb_pkg::LWB_AWAKE) && !clk_gate_n;
    selected  = !select_one_n && select_two && !select_three_n;
    any_lane  = ~&lane_strobe_n;
    cur_addr  = {st_reg.base[ADDR_W-1:2], bif.addr};
  end

  always_comb begin
    bif.load       = run && !next_or_load && selected;
    bif.step       = run && next_or_load && (st_reg.last != lwb_pkg::LWB_DESEL)
                     && (st_reg.last != lwb_pkg::LWB_IDLE);
    bif.start      = addr[1:0];
    bif.interleave = seq_order_sel_n;
  end

  // read word for the address at stage 1
  assign rd_word = mem[st_reg.cyc_addr[IDX_W-1:0]];

  always_comb begin
    st_next = st_reg;
    cur_wr  = 1'b0;
    cur_acc = 1'b0;
    mem_we     = 1'b0;
    mem_waddr  = st_reg.w2_addr;
    mem_wlanes = st_reg.w2_lanes;
    // sleep sequencing
    case (st_reg.slp)
      lwb_pkg::LWB_AWAKE: begin
        if (sleep_request) begin
          st_next.slp     = lwb_pkg::LWB_ENTER;
          st_next.slp_cnt = 2'(lwb_pkg::SLEEP_ENTRY_CYC - 1);
        end
      end
      lwb_pkg::LWB_ENTER: begin
        if (st_reg.slp_cnt == 2'h1) begin
          st_next.slp = lwb_pkg::LWB_ASLEEP;
        end
        st_next.slp_cnt = st_reg.slp_cnt - 2'h1;
      end
      lwb_pkg::LWB_ASLEEP: begin
        if (!sleep_request) begin
          st_next.slp     = lwb_pkg::LWB_WAKING;
          st_next.slp_cnt = 2'(lwb_pkg::SLEEP_EXIT_CYC - 1);
        end
      end
      lwb_pkg::LWB_WAKING: begin
        if (st_reg.slp_cnt == 2'h1) begin
          st_next.slp = lwb_pkg::LWB_AWAKE;
        end
        st_next.slp_cnt = st_reg.slp_cnt - 2'h1;
      end
      default: st_next.slp = lwb_pkg::LWB_AWAKE;
    endcase
    st_next.asleep = (st_next.slp != lwb_pkg::LWB_AWAKE);

    if (run) begin
      // retire pipelined write with data at third edge
      if (st_reg.w2_vld) begin
        mem_we = 1'b1;
      end
      st_next.w2_vld = 1'b0;
      if (st_reg.cyc_vld && st_reg.cyc_wr) begin
        if (pipelined) begin
          st_next.w2_vld   = 1'b1;
          st_next.w2_addr  = st_reg.cyc_addr;
          st_next.w2_lanes = st_reg.cyc_lanes;
        end else begin
          mem_we     = 1'b1;
          mem_waddr  = st_reg.cyc_addr;
          mem_wlanes = st_reg.cyc_lanes;
        end
      end
      // output register loads read data
      st_next.rd_drive = st_reg.cyc_vld && !st_reg.cyc_wr && st_reg.cyc_drive;
      st_next.rd_data  = rd_word;
      // command decode
      if (!next_or_load) begin
        if (!selected) begin
          st_next.last = lwb_pkg::LWB_DESEL;
        end else if (store_n) begin
          st_next.last = lwb_pkg::LWB_READ;
          cur_acc      = 1'b1;
        end else if (any_lane) begin
          st_next.last = lwb_pkg::LWB_WRITE;
          cur_acc      = 1'b1;
          cur_wr       = 1'b1;
        end else begin
          st_next.last = lwb_pkg::LWB_ABORT;
        end
        if (selected) begin
          st_next.base = addr;
        end
      end else begin
        case (st_reg.last)
          lwb_pkg::LWB_READ: begin
            cur_acc = 1'b1;
          end
          lwb_pkg::LWB_WRITE,
          lwb_pkg::LWB_ABORT: begin
            cur_acc = any_lane;
            cur_wr  = any_lane;
          end
          default: cur_acc = 1'b0;
        endcase
      end
      st_next.cyc_vld   = cur_acc;
      st_next.cyc_wr    = cur_wr;
      st_next.cyc_drive = !out_en_n;
      st_next.cyc_addr  = bif.load ? addr : cur_addr;
      st_next.cyc_lanes = ~lane_strobe_n;
    end

    // pin drive: flow-through uses stage 1, pipelined uses output register
    if (st_next.slp != lwb_pkg::LWB_AWAKE) begin
      st_next.oe = 1'b0;
    end else if (!run) begin
      st_next.oe = st_reg.oe && st_reg.slp == lwb_pkg::LWB_AWAKE;
    end else if (pipelined) begin
      st_next.oe   = st_next.rd_drive && !out_en_n;
      st_next.dout = st_next.rd_data;
    end else begin
      st_next.oe   = st_next.cyc_vld && !st_next.cyc_wr && !out_en_n;
      st_next.dout = mem[st_next.cyc_addr[IDX_W-1:0]];
    end
  end

  // lane strobes widened to a bit mask, one lane per generate pass
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign mem_wmask[g*LANE_W +: LANE_W] = {LANE_W{mem_wlanes[g]}};
  end

  // single writer keeps the array on one process; unmasked lanes keep old bits
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_waddr[IDX_W-1:0]] <= (mem[mem_waddr[IDX_W-1:0]] & ~mem_wmask) | (dq_in & mem_wmask);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= '0;
      st_reg.last <= lwb_pkg::LWB_IDLE;
      st_reg.slp  <= lwb_pkg::LWB_AWAKE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dq_out = st_reg.dout;
  assign dq_oe  = {DATA_W{st_reg.oe}};
  assign asleep = st_reg.asleep;
endmodule : lwb_ctrl
`default_nettype wire

/* bench/lwb_ctrl_props.sv */
// lwb_ctrl_props: port checks for lwb_ctrl
// assumes: bound to every lwb_ctrl instance, one clock
`timescale 1ns/1ns
`default_nettype none
module lwb_ctrl_props #(
  parameter int unsigned DATA_W = 36,
  parameter int unsigned LANES  = 4
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              nrst,
  // command and mode pins
  input wire logic              clk_gate_n,
  input wire logic              next_or_load,
  input wire logic              store_n,
  input wire logic [LANES-1:0]  lane_strobe_n,
  input wire logic              select_one_n,
  input wire logic              select_two,
  input wire logic              select_three_n,
  input wire logic              out_en_n,
  input wire logic              passthru_sel_n,
  input wire logic              sleep_request,
  // outputs
  input wire logic [DATA_W-1:0] dq_oe,
  input wire logic              asleep
);
  wire logic ld  = !clk_gate_n && !asleep && !sleep_request && !next_or_load;
  wire logic sel = !select_one_n && select_two && !select_three_n;
  wire logic rd  = ld && sel && store_n;
  wire logic off = (dq_oe == '0);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_RD_PIPE: assert property (rd && !out_en_n && passthru_sel_n ##1 (!clk_gate_n && !out_en_n) |=> &dq_oe)
    else $error("read not driven");
  AST_WR_OFF: assert property (ld && sel && !store_n && !(&lane_strobe_n) ##1 !clk_gate_n |=> off)
    else $error("write slot driven");
  AST_DESEL_OFF: assert property (ld && !sel ##1 (!clk_gate_n && next_or_load) |=> off)
    else $error("deselect driven");
  AST_DUMMY_OFF: assert property (rd && out_en_n ##1 (!clk_gate_n && out_en_n) |=> off)
    else $error("dummy read driven");
  AST_STALL: assert property (clk_gate_n && !asleep && !sleep_request |=> $stable(dq_oe))
    else $error("stall moved bus");
  AST_SLEEP_IN: assert property ($rose(sleep_request) |-> ##[1:2] asleep)
    else $error("sleep entry late");
  AST_ASLEEP_OFF: assert property (sleep_request [*3] |-> off && asleep)
    else $error("asleep but driving");
  AST_WAKE: assert property ($fell(sleep_request) |-> ##[1:4] !asleep)
    else $error("wake late");
  AST_RESET_OFF: assert property (disable iff (1'b0) (!nrst) [*2] |-> off && !asleep)
    else $error("driving in reset");
endmodule : lwb_ctrl_props
bind lwb_ctrl lwb_ctrl_props #(.DATA_W(DATA_W), .LANES(LANES)) u_props (
  .sys_clk(sys_clk), .nrst(nrst), .clk_gate_n(clk_gate_n), .next_or_load(next_or_load),
  .store_n(store_n), .lane_strobe_n(lane_strobe_n), .select_one_n(select_one_n),
  .select_two(select_two), .select_three_n(select_three_n), .out_en_n(out_en_n),
  .passthru_sel_n(passthru_sel_n), .sleep_request(sleep_request), .dq_oe(dq_oe), .asleep(asleep));
`default_nettype wire

/* bench/lwb_host_model.sv */
// lwb_host_model: controller side of the data pins
// assumes: wr_go high for the cycle that issues each write beat
`timescale 1ns/1ns
`default_nettype none
module lwb_host_model #(
  parameter int unsigned DATA_W = 36
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // write beats
  input  wire logic              wr_go,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              passthru_sel_n,
  // data pins
  output logic      [DATA_W-1:0] dq_in
);
  logic              late_reg;
  logic [DATA_W-1:0] data_reg;
  // idle pins toggle so stale data never looks valid
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      late_reg <= 1'b0;
      data_reg <= '0;
      dq_in    <= '0;
    end else begin
      late_reg <= wr_go && passthru_sel_n;
      data_reg <= wr_data;
      if (late_reg) dq_in <= data_reg;
      else if (wr_go && !passthru_sel_n) dq_in <= wr_data;
      else dq_in <= ~dq_in;
    end
  end
endmodule : lwb_host_model
`default_nettype wire

/* bench/tb_late_write_burst_sram_control.sv */
// tb_late_write_burst_sram_control: directed bench for lwb_ctrl
// assumes: rtl, checker and host model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_late_write_burst_sram_control;
  logic        sys_clk, nrst, clk_gate_n, next_or_load, store_n, select_one_n, select_two, select_three_n;
  logic        out_en_n, seq_order_sel_n, passthru_sel_n, sleep_request, asleep, wr_go, pt, ord, zz;
  logic [3:0]  lane_strobe_n;
  logic [19:0] addr;
  logic [35:0] dq_in, dq_out, dq_oe, wr_data, mem [4], ed [8];
  logic        chk [8], eo [8];
  logic        held;
  logic [71:0] hp;
  int          error_cnt, comparisons, n;
  always #5 sys_clk = ~sys_clk;
  lwb_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .clk_gate_n(clk_gate_n), .next_or_load(next_or_load),
    .store_n(store_n), .lane_strobe_n(lane_strobe_n), .select_one_n(select_one_n), .select_two(select_two),
    .select_three_n(select_three_n), .out_en_n(out_en_n), .addr(addr), .seq_order_sel_n(seq_order_sel_n),
    .passthru_sel_n(passthru_sel_n), .sleep_request(sleep_request), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .asleep(asleep));
  lwb_host_model host (.sys_clk(sys_clk), .nrst(nrst), .wr_go(wr_go), .wr_data(wr_data),
    .passthru_sel_n(passthru_sel_n), .dq_in(dq_in));
  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // one active edge; v is write data or expected read data
  task automatic cyc(input logic nl, st, input logic [3:0] ln, input logic sel, oe, input logic [1:0] a,
                     input logic [35:0] v, input logic on);
    int k, s;
    @(posedge sys_clk);
    {clk_gate_n, next_or_load, store_n, lane_strobe_n, out_en_n} <= {1'b0, nl, st, ln, oe};
    {select_one_n, select_two, select_three_n} <= {!sel, sel, !sel};
    {addr, passthru_sel_n, seq_order_sel_n, sleep_request} <= {18'h0_0015, a, pt, ord, zz};
    wr_go <= !(&ln);
    wr_data <= v;
    n++;
    k = (n + 1 + pt) % 8;
    {chk[k], eo[k], ed[k]} = {1'b1, on, v};
    @(negedge sys_clk);
    s = n % 8;
    if (chk[s]) check(dq_oe === {36{eo[s]}} && (!eo[s] || dq_out === ed[s]), "pins");
    chk[s] = 1'b0;
    if (held) check({dq_oe, dq_out} === hp, "stall");
    held = 1'b0;
  endtask : cyc
  // gate is taken at the next edge; the following cyc compares across it
  task automatic stall();
    @(posedge sys_clk);
    clk_gate_n <= 1'b1;
    @(negedge sys_clk);
    {held, hp} = {1'b1, dq_oe, dq_out};
  endtask : stall
  task automatic burst(input logic p, o, input logic [1:0] ws, rs);
    logic [1:0] w;
    {pt, ord} = {p, o};
    cyc(1'b0, 1'b0, 4'hF, 1'b1, 1'b0, ws, '0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      w = o ? ws ^ 2'(i) : ws + 2'(i);
      if (i != 4) mem[w] = 36'h9_A5C3_0000 ^ 36'(n * 7919);
      cyc(i != 0, 1'b0, (i == 4) ? 4'hF : 4'h0, 1'b1, 1'b0, ws, mem[w], 1'b0);
    end
    cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b0, ws, '0, 1'b0);
    for (int j = 0; j < 5; j++) begin
      w = o ? rs ^ 2'(j) : rs + 2'(j);
      if (j == 2) stall();
      cyc(j != 0, 1'b1, 4'hF, 1'b1, 1'b0, rs, mem[w], 1'b1);
    end
    repeat (3) cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b0, rs, '0, 1'b0);
    $display("burst test done");
  endtask : burst
  task automatic sleep_test();
    zz = 1'b1;
    repeat (3) cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b0, 2'h1, '0, 1'b0);
    check(asleep === 1'b1, "asleep");
    repeat (2) cyc(1'b0, 1'b0, 4'h0, 1'b1, 1'b0, 2'h1, 36'h0_DEAD_BEEF, 1'b0);
    zz = 1'b0;
    repeat (2) cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b0, 2'h1, '0, 1'b0);
    check(asleep === 1'b1, "waking");
    cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b0, 2'h1, '0, 1'b0);
    check(asleep === 1'b0, "awake");
    cyc(1'b0, 1'b1, 4'hF, 1'b1, 1'b1, 2'h1, '0, 1'b0);
    cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b1, 2'h1, '0, 1'b0);
    cyc(1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 2'h1, 36'h0_BAD0_0001, 1'b0);
    cyc(1'b0, 1'b1, 4'hF, 1'b1, 1'b0, 2'h1, mem[1], 1'b1);
    cyc(1'b1, 1'b1, 4'hF, 1'b1, 1'b0, 2'h1, mem[0], 1'b1);
    repeat (3) cyc(1'b0, 1'b1, 4'hF, 1'b0, 1'b0, 2'h0, '0, 1'b0);
    $display("sleep test done");
  endtask : sleep_test
  initial begin
    {sys_clk, nrst, clk_gate_n, next_or_load, select_one_n, select_two, select_three_n, out_en_n} = '0;
    {seq_order_sel_n, sleep_request, wr_go, ord, zz, addr, wr_data, n, error_cnt, comparisons} = '0;
    {store_n, passthru_sel_n, pt, lane_strobe_n} = '1;
    foreach (chk[i]) chk[i] = 1'b0;
    held = 1'b0;
    repeat (3) @(posedge sys_clk);
    check(dq_oe === '0 && asleep === 1'b0, "reset");
    nrst <= 1'b1;
    burst(1'b1, 1'b0, 2'h2, 2'h1);
    burst(1'b0, 1'b1, 2'h1, 2'h3);
    burst(1'b0, 1'b0, 2'h3, 2'h0);
    burst(1'b1, 1'b1, 2'h0, 2'h2);
    sleep_test();
    summarize();
  end
  initial begin
    #20000;
    error_cnt++;
    $display("ERROR %0t watchdog", $time);
    summarize();
  end
endmodule : tb_late_write_burst_sram_control
`default_nettype wire
